/* File: pkg/cpw_pkg.sv */
// Function
// - two linked channels run complementary PWM variant 2 as output pairs.
// - conversion start triggers are issued only while the carrier counts up.
// - a new duty value takes effect only at the carrier trough.
// - channel A count equal to compare register A raises an unskipped event.
// - a conversion request fires when the counter matches the peak value.
// - a conversion request fires on cycle-set A match, up-count matches only.
// - cycle-set register A starts at 16 counts.
// - the buffer feeding cycle-set register A also starts at 16 counts.
// - output-level buffer stays inactive; no level is ever copied from it.
// - all four phase outputs are active high.
package cpw_pkg;
    localparam int          CLK_FREQ_KHZ      = 10000;
    localparam int          CARRIER_PERIOD_NS = 10000;
    localparam int          DEAD_TIME_NS      = 500;
    // full triangle of 2*peak cycles spans one carrier period
    localparam int          PERIOD_CYC  = CARRIER_PERIOD_NS * CLK_FREQ_KHZ
                                          / 1000000;
    localparam int          PEAK_CYC    = PERIOD_CYC / 2;
    // least time: round up
    localparam int          DEAD_CYC    = (DEAD_TIME_NS * CLK_FREQ_KHZ
                                           + 999999) / 1000000;
    localparam int          CNT_W       = 16;
    localparam logic [15:0] TRIG_INIT   = 16'h0010;
    localparam logic [15:0] PEAK_VAL    = 16'(PEAK_CYC);
    localparam logic [15:0] DUTY_INIT   = 16'h0000;
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_DUTY_V  = 8'h04;
    localparam logic [7:0]  OFS_DUTY_W  = 8'h08;
    localparam logic [7:0]  OFS_TRIG    = 8'h0c;
    localparam logic [7:0]  OFS_STATUS  = 8'h10;
    localparam logic [7:0]  OFS_MASK    = 8'h14;
    localparam logic [7:0]  OFS_CNT     = 8'h18;
    localparam logic [7:0]  OFS_TRIG_A  = 8'h1c;
    // field positions
    localparam int          CTRL_RUN    = 0;
    localparam int          ST_CMPA     = 0;
    localparam int          ST_TRIG     = 1;
    localparam int          ST_W        = 2;
    localparam int          CNT_DIR_BIT = 16;
endpackage

/* File: pkg/cpw_carrier_if.sv */
`timescale 1ns/10ps
interface cpw_carrier_if;
    logic [15:0] cnt;
    logic        up;
    logic        trough;
    logic        peak;
    modport src (output cnt, output up, output trough, output peak);
    modport snk (input cnt, input up, input trough, input peak);
endinterface

/* File: design/cpw_carrier.sv */
`timescale 1ns/10ps
module cpw_carrier #(
    parameter logic [15:0] PEAK = cpw_pkg::PEAK_VAL
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    cpw_carrier_if.src      car
);
    import cpw_pkg::*;
    logic [15:0] cnt_q;
    logic        up_q;
    wire         at_peak   = up_q && (cnt_q == PEAK);
    wire         at_trough = !up_q && (cnt_q == 16'h0001);

    // triangle straight from pclk, cleared to zero and held there while run is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 16'h0000;
            up_q  <= 1'b1;
        end else if (!run) begin
            cnt_q <= 16'h0000;
            up_q  <= 1'b1;
        end else if (at_peak) begin
            cnt_q <= cnt_q - 16'h0001;
            up_q  <= 1'b0;
        end else if (at_trough) begin
            cnt_q <= 16'h0000;
            up_q  <= 1'b1;
        end else if (up_q) begin
            cnt_q <= cnt_q + 16'h0001;
        end else begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end

    assign car.cnt    = cnt_q;
    assign car.up     = up_q;
    assign car.peak   = run && at_peak;
    assign car.trough = run && (cnt_q == 16'h0000);
endmodule // cpw_carrier

/* File: design/cpw_deadtime.sv */
`timescale 1ns/10ps
module cpw_deadtime #(
    parameter int DEAD = cpw_pkg::DEAD_CYC
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run,
    input  wire logic raw,
    output logic      pos_q,
    output logic      neg_q
);
    import cpw_pkg::*;
    logic       raw_q;
    logic [7:0] dt_q;
    // the cycle that sees the edge is the first of the dead cycles
    wire        settled = (({1'b0, dt_q} + 9'h001) >= 9'(DEAD));
    wire        change  = (raw != raw_q);

    // both legs held off for the dead time after every edge of raw
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_q <= 1'b0;
            dt_q  <= 8'h00;
        end else if (change || !run) begin
            raw_q <= raw;
            dt_q  <= 8'h00;
        end else if (!settled) begin
            dt_q  <= dt_q + 8'h01;
        end
    end

    // fixed high active level; no level buffer exists to reload it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q <= 1'b0;
            neg_q <= 1'b0;
        end else begin
            pos_q <= run && !change && settled && raw_q;
            neg_q <= run && !change && settled && !raw_q;
        end
    end

    AST_DT_GAP: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(neg_q) |-> !pos_q [*5])
        else $error("positive leg rose inside the dead time");
    AST_NO_OVERLAP: assert property (@(posedge pclk) disable iff (!presetn)
        !(pos_q && neg_q))
        else $error("both legs of a phase active together");
endmodule // cpw_deadtime

/* File: design/cpw_top.sv */
`timescale 1ns/10ps
module cpw_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             v_phase_positive_out,
    output logic             v_phase_negative_out,
    output logic             w_phase_positive_out,
    output logic             w_phase_negative_out,
    output logic             chan_a_compare_a_event,
    output logic             combined_conversion_trigger,
    output logic             irq
);
    import cpw_pkg::*;

    cpw_carrier_if car ();

    logic        run_q;
    logic [15:0] duty_v_buf_q;
    logic [15:0] duty_w_buf_q;
    logic [15:0] duty_v_q;
    logic [15:0] duty_w_q;
    logic [15:0] trig_buf_q;
    logic [15:0] trig_set_q;
    logic [ST_W-1:0] status_q;
    logic [ST_W-1:0] status_d;
    logic [ST_W-1:0] mask_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        cmpa_q;
    logic        trig_q;
    logic        irq_q;
    logic [1:0]  pos_w;
    logic [1:0]  neg_w;

    // ---------------- apb slave: no wait states, data latched in setup
    wire setup    = psel && !penable;
    wire access   = psel && penable && pready_q;
    wire wr_acc   = access && pwrite;
    wire rd_acc   = access && !pwrite;
    wire hit_ctrl = (paddr == OFS_CTRL);
    wire hit_dv   = (paddr == OFS_DUTY_V);
    wire hit_dw   = (paddr == OFS_DUTY_W);
    wire hit_trig = (paddr == OFS_TRIG);
    wire hit_st   = (paddr == OFS_STATUS);
    wire hit_mask = (paddr == OFS_MASK);
    wire hit_cnt  = (paddr == OFS_CNT);
    wire hit_trga = (paddr == OFS_TRIG_A);
    wire mapped   = hit_ctrl || hit_dv || hit_dw || hit_trig || hit_st
                    || hit_mask || hit_cnt || hit_trga;

    logic [31:0] rd_mux;
    always_comb begin
        if (hit_ctrl) begin
            rd_mux = {31'h0, run_q};
        end else if (hit_dv) begin
            rd_mux = {16'h0, duty_v_buf_q};
        end else if (hit_dw) begin
            rd_mux = {16'h0, duty_w_buf_q};
        end else if (hit_trig) begin
            rd_mux = {16'h0, trig_buf_q};
        end else if (hit_st) begin
            rd_mux = {30'h0, status_q};
        end else if (hit_mask) begin
            rd_mux = {30'h0, mask_q};
        end else if (hit_cnt) begin
            rd_mux = {15'h0, car.up, car.cnt};
        end else if (hit_trga) begin
            rd_mux = {16'h0, trig_set_q};
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !mapped;
            if (setup) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // ---------------- software registers
    // duty buffers are the landing spot of apb writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q        <= 1'b0;
            duty_v_buf_q <= DUTY_INIT;
            duty_w_buf_q <= DUTY_INIT;
            trig_buf_q   <= TRIG_INIT;
            mask_q       <= '0;
        end else if (wr_acc) begin
            if (hit_ctrl) run_q <= pwdata[CTRL_RUN];
            if (hit_dv) duty_v_buf_q <= pwdata[15:0];
            if (hit_dw) duty_w_buf_q <= pwdata[15:0];
            if (hit_trig) trig_buf_q <= pwdata[15:0];
            if (hit_mask) mask_q <= pwdata[ST_W-1:0];
        end
    end

    // ---------------- carrier and trough reload
    cpw_carrier #(
        .PEAK    (PEAK_VAL)
    ) u_carrier (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (run_q),
        .car     (car.src)
    );

    // compare values only move at the trough, never mid-period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_v_q   <= DUTY_INIT;
            duty_w_q   <= DUTY_INIT;
            trig_set_q <= TRIG_INIT;
        end else if (car.trough) begin
            duty_v_q   <= duty_v_buf_q;
            duty_w_q   <= duty_w_buf_q;
            trig_set_q <= trig_buf_q;
        end
    end

    // ---------------- complementary phases with dead time
    wire [1:0] raw = {car.cnt < duty_w_q, car.cnt < duty_v_q};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_phase
            cpw_deadtime #(
                .DEAD    (DEAD_CYC)
            ) u_dt (
                .pclk    (pclk),
                .presetn (presetn),
                .run     (run_q),
                .raw     (raw[g]),
                .pos_q   (pos_w[g]),
                .neg_q   (neg_w[g])
            );
        end
    endgenerate

    assign v_phase_positive_out = pos_w[0];
    assign v_phase_negative_out = neg_w[0];
    assign w_phase_positive_out = pos_w[1];
    assign w_phase_negative_out = neg_w[1];

    // ---------------- events and conversion triggers
    // every match fires: no skipping counter on this event
    wire cmpa_hit = run_q && (car.cnt == duty_v_q);
    // down-count matches are dropped so sampling sits mid-pulse
    wire trig_hit = run_q && car.up
                    && (car.peak || car.cnt == trig_set_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmpa_q <= 1'b0;
            trig_q <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            cmpa_q <= cmpa_hit;
            trig_q <= trig_hit;
            irq_q  <= |(status_d & mask_q);
        end
    end

    // a new event in the clearing read's cycle survives the clear
    wire [ST_W-1:0] st_set = {trig_hit, cmpa_hit};
    wire [ST_W-1:0] st_clr = (rd_acc && hit_st) ? '1 : '0;
    assign status_d = (status_q & ~st_clr) | st_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    assign prdata                      = prdata_q;
    assign pready                      = pready_q;
    assign pslverr                     = pslverr_q;
    assign chan_a_compare_a_event      = cmpa_q;
    assign combined_conversion_trigger = trig_q;
    assign irq                         = irq_q;

    // ---------------- checks
    logic started_q;
    logic trig_wr_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            started_q <= 1'b0;
            trig_wr_q <= 1'b0;
        end else begin
            if (car.trough) started_q <= 1'b1;
            if (wr_acc && hit_trig) trig_wr_q <= 1'b1;
        end
    end

    AST_TRIG_UP: assert property (@(posedge pclk) disable iff (!presetn)
        combined_conversion_trigger |-> $past(car.up))
        else $error("conversion trigger issued on down count");
    AST_DUTY_TROUGH: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(duty_v_q) |-> $past(car.trough))
        else $error("duty changed away from the trough");
    AST_CMPA: assert property (@(posedge pclk) disable iff (!presetn)
        (run_q && car.cnt == duty_v_q) |=> chan_a_compare_a_event)
        else $error("compare A match gave no event");
    AST_PEAK_TRIG: assert property (@(posedge pclk) disable iff (!presetn)
        car.peak |=> combined_conversion_trigger)
        else $error("peak match gave no conversion trigger");
    AST_SETA_TRIG: assert property (@(posedge pclk) disable iff (!presetn)
        (run_q && car.up && car.cnt == trig_set_q)
        |=> combined_conversion_trigger)
        else $error("cycle-set A up match gave no trigger");
    AST_SETA_INIT: assert property (@(posedge pclk) disable iff (!presetn)
        !started_q |-> trig_set_q == 16'h0010)
        else $error("cycle-set A not at 16 before first reload");
    AST_SETA_BUF: assert property (@(posedge pclk) disable iff (!presetn)
        !trig_wr_q |-> trig_buf_q == 16'h0010)
        else $error("cycle-set buffer A not at 16 before a write");
    AST_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
        (car.trough && run_q) |-> ##100 (car.trough || !run_q))
        else $error("carrier period is not 100 cycles");

    COV_TRIG: cover property (@(posedge pclk) disable iff (!presetn)
        combined_conversion_trigger);
    COV_RELOAD: cover property (@(posedge pclk) disable iff (!presetn)
        car.trough && duty_v_buf_q != duty_v_q);
    COV_IRQ_CLR: cover property (@(posedge pclk) disable iff (!presetn)
        irq ##1 (rd_acc && hit_st));
endmodule // cpw_top

/* File: testbench/cpw_power_stage_model.sv */
`timescale 1ns/10ps
// stands for the bridge and module: counts how long each leg conducts
module cpw_power_stage_model (
    input  wire logic pclk,
    input  wire logic clr,
    input  wire logic vp,
    input  wire logic vn,
    input  wire logic wp,
    input  wire logic wn,
    output int        vp_hi,
    output int        vn_hi,
    output int        wp_hi,
    output int        wn_hi,
    output int        shoot
);
    // a pair with both legs on would short the supply rail
    always @(posedge pclk) begin
        if (clr) begin
            vp_hi <= 0;
            vn_hi <= 0;
            wp_hi <= 0;
            wn_hi <= 0;
            shoot <= 0;
        end else begin
            vp_hi <= vp_hi + int'(vp === 1'b1);
            vn_hi <= vn_hi + int'(vn === 1'b1);
            wp_hi <= wp_hi + int'(wp === 1'b1);
            wn_hi <= wn_hi + int'(wn === 1'b1);
            shoot <= shoot + int'((vp & vn) | (wp & wn));
        end
    end
endmodule // cpw_power_stage_model

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
    fails++; $display("unexpected at %0t got %0h exp %0h", \
    $time, (g), (e)); end end
module tb_top;
    import cpw_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, clr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, d;
    logic        pready, pslverr, vp, vn, wp, wn, evt, trig, irq, e;
    int          fails, cmp_count, vp_hi, vn_hi, wp_hi, wn_hi, shoot;
    int          n1, n2, k;
    logic [7:0]  ofs [8];
    logic [31:0] rst_val [8];

    cpw_top u_dut (
        .pclk                       (pclk),
        .presetn                    (presetn),
        .psel                       (psel),
        .penable                    (penable),
        .pwrite                     (pwrite),
        .paddr                      (paddr),
        .pwdata                     (pwdata),
        .prdata                     (prdata),
        .pready                     (pready),
        .pslverr                    (pslverr),
        .v_phase_positive_out       (vp),
        .v_phase_negative_out       (vn),
        .w_phase_positive_out       (wp),
        .w_phase_negative_out       (wn),
        .chan_a_compare_a_event     (evt),
        .combined_conversion_trigger(trig),
        .irq                        (irq)
    );
    cpw_power_stage_model u_stage (
        .pclk (pclk), .clr (clr), .vp (vp), .vn (vn), .wp (wp), .wn (wn),
        .vp_hi(vp_hi), .vn_hi(vn_hi), .wp_hi(wp_hi), .wn_hi(wn_hi),
        .shoot(shoot)
    );

    always #50 pclk = ~pclk;

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // entered just after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fails++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] r;
        logic        x;
        apb(1'b1, a, v, r, x);
    endtask

    // cycles until the next conversion request pulse
    task automatic wait_trig(output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (trig !== 1'b1 && n < 300);
        if (trig !== 1'b1) begin
            fails++;
            tally_and_finish();
        end
    endtask

    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 8'h00; pwdata = 32'h0; clr = 0;
        fails = 0; cmp_count = 0;
        ofs = '{OFS_CTRL, OFS_DUTY_V, OFS_DUTY_W, OFS_TRIG, OFS_STATUS,
                OFS_MASK, OFS_CNT, OFS_TRIG_A};
        rst_val = '{32'h0, 32'h0, 32'h0, 32'h10, 32'h0, 32'h0, 32'h1_0000,
                    32'h10};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (k = 0; k < 8; k++) begin
            apb(1'b0, ofs[k], 32'h0, d, e);
            `CHK(d, rst_val[k])
        end
        apb(1'b0, 8'h20, 32'h0, d, e);
        `CHK({e, d}, 33'h1_0000_0000)
        `CHK({vp, vn, wp, wn}, 4'h0)
        $display("test reset_values done");

        wr(OFS_DUTY_V, 32'd20);
        wr(OFS_DUTY_W, 32'd30);
        wr(OFS_CTRL, 32'h1);
        repeat (250) @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        // one extra edge so the model's 100th count has landed
        repeat (101) @(posedge pclk);
        // high span is 2*duty-1 counts, minus the dead time on each rise
        `CHK(vp_hi, 39 - DEAD_CYC)
        `CHK(vn_hi, PERIOD_CYC - 39 - DEAD_CYC)
        `CHK(wp_hi, 59 - DEAD_CYC)
        `CHK(wn_hi, PERIOD_CYC - 59 - DEAD_CYC)
        `CHK(shoot, 0)
        $display("test duty_widths done");

        // 16 up to peak 50 is 34 cycles; any down-count request breaks it
        wait_trig(n1);
        wait_trig(n1);
        wait_trig(n2);
        `CHK(n1 * n2, 34 * 66)
        n1 = 0;
        repeat (100) begin
            @(posedge pclk);
            n1 += int'(evt === 1'b1);
        end
        `CHK(n1, 2)
        `CHK(irq, 1'b0)
        apb(1'b0, OFS_STATUS, 32'h0, d, e);
        `CHK(d, 32'h3)
        $display("test triggers done");

        // move the request point just after the 16 match, far from trough
        n2 = 0;
        for (k = 0; k < 3 && n2 != 66; k++)
            wait_trig(n2);
        wr(OFS_TRIG, 32'd30);
        apb(1'b0, OFS_TRIG_A, 32'h0, d, e);
        `CHK(d, 32'h10)
        repeat (100) @(posedge pclk);
        apb(1'b0, OFS_TRIG_A, 32'h0, d, e);
        `CHK(d, 32'd30)
        wait_trig(n1);
        wait_trig(n1);
        wait_trig(n2);
        `CHK(n1 * n2, 20 * 80)
        $display("test trigger_reload done");

        wr(OFS_MASK, 32'h3);
        repeat (110) @(posedge pclk);
        `CHK(irq, 1'b1)
        wr(OFS_CTRL, 32'h0);
        repeat (3) @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0, d, e);
        `CHK(d, 32'h3)
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1'b0, OFS_STATUS, 32'h0, d, e);
        `CHK(d, 32'h0)
        `CHK({vp, vn, wp, wn}, 4'h0)
        apb(1'b0, OFS_CNT, 32'h0, d, e);
        `CHK(d[15:0], 16'h0000)
        $display("test irq_stop done");
        tally_and_finish();
    end
endmodule // tb_top
